// ===== design/smcmp_seq.sv
// memory cycle sequencer, merge register and byte parity generator
// assumes start and write request come from logic on core_clk_in
//
// Summary of operation
// - a cycle starts only on a start pulse; levels go to all modules.
// - without write request the cycle is a read ending at T500.
// - write request at T250 stretches the cycle to T750 and selects write.
// - write request and delay tap keep chip select past T500, off before T750.
// - read keeps read/write low; precharge 87-235ns, chip select 193-475ns.
// - write: chip select 193-710ns, write level 520-710ns, data 530-750ns.
// - micro fetch loads fetch latch; address bit picks low or high half.
// - micro fetch is word addressed and bypasses the rotator.
// - move micro read data goes rotator, merge register, then X/Y/L/T.
// - read data is parity checked; an error sets the parity error flag.
// - write data from X, Y, T, L or console, via exchange and rotator.
// - merge picks rotator bits where mask set, read data where clear.
// - merge register shared with other micros; 7D loads without rotation.
// - one parity bit per byte gives an odd count of ones.
// - parity made on write cycles only, from the merged word.
// - a byte with a read parity error gets bad parity written back.
// - field length 25 forces good parity despite read errors.
// - field length 26 writes bad parity on every byte.
// - four byte sections; good parity only if manipulate set and not 26.
//
// Implementation choices: register access over APB and the register offsets.
`include "smcmp_defines.svh"
module smcmp_seq (
  // clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  srst_in,
  // apb slave
  input  wire smcmp_pkg::smcmp_apb_req_t apb_in,
  output logic                       pready_out,
  output logic                       pslverr_out,
  output logic [31:0]                prdata_out,
  // processor control
  input  wire logic                  mem_start_pulse_in,
  input  wire logic                  write_request_in,
  input  wire logic                  micro_fetch_in,
  input  wire logic                  halfword_select_bit_in,
  input  wire logic [1:0]            dest_sel_in,
  input  wire logic [4:0]            rot_amt_in,
  input  wire logic [31:0]           mask_in,
  input  wire smcmp_pkg::smcmp_src_t src_sel_in,
  input  wire logic [23:0]           x_reg_in,
  input  wire logic [23:0]           y_reg_in,
  input  wire logic [23:0]           t_reg_in,
  input  wire logic [23:0]           l_reg_in,
  input  wire logic [23:0]           console_sw_in,
  // shared use of the merge register
  input  wire logic                  share_load_in,
  input  wire logic                  share_rotate_in,
  input  wire logic [31:0]           share_data_in,
  // processor results
  output logic                       busy_out,
  output logic [15:0]                micro_reg_out,
  output logic                       micro_load_out,
  output logic [31:0]                merge_data_out,
  output logic [1:0]                 dest_sel_out,
  output logic                       dest_load_out,
  // memory modules
  output smcmp_pkg::smcmp_mem_lvl_t  mem_lvl_out,
  input  wire logic [31:0]           mem_rdata_in,
  input  wire logic [3:0]            mem_rpar_in,
  output logic [31:0]                merged_write_levels_out,
  output logic [3:0]                 module_parity_out
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // left rotate, shared by read and write paths
  function automatic logic [31:0] smcmp_rotl(input logic [31:0] d,
                                             input logic [4:0] n);
    logic [63:0] w;
    w = {d, d} << n;
    return w[63:32];
  endfunction : smcmp_rotl
  // odd parity bit of one byte
  function automatic logic smcmp_odd(input logic [7:0] b);
    return ~(^b);
  endfunction : smcmp_odd
  // cycle counter window test
  function automatic logic smcmp_win(input logic [6:0] c,
                                     input int lo, input int hi);
    return (c >= 7'(lo)) && (c < 7'(hi));
  endfunction : smcmp_win
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  smcmp_pkg::smcmp_state_t state_ff;
  logic [6:0]  cyc_ff;
  logic        wr_ff;
  logic        fetch_ff;
  logic        half_ff;
  logic [1:0]  dsel_ff;
  logic [4:0]  rot_ff;
  logic [31:0] mask_ff;
  logic [31:0] merge_ff;
  logic [31:0] fetch_latch_register_ff;
  logic [3:0]  rd_err_ff;
  logic [4:0]  dfl_ff;
  logic        perr_ff;
  logic        last_wr_ff;
  logic        micro_pend_ff;
  logic [15:0] micro_ff;
  logic        dest_load_ff;
  logic [3:0]  wpar_ff;
  logic [31:0] prdata_ff;
  logic        busy;
  logic        smp;
  logic        ce_hold_delay_tap;
  logic [31:0] exch;
  logic [3:0]  chk_err;
  logic [3:0]  nxt_par;
  logic        force_good_parity_code;
  logic        not_force_bad_parity;
  logic [3:0]  parity_manipulate_term;
  logic        acc;
  logic        map_ok;
  logic        st_clr;
  assign busy = (state_ff != smcmp_pkg::ST_IDLE);
  assign smp  = busy && (cyc_ff == 7'(`SMCMP_RD_SMP_CYC));
  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  // one counter stands in for the whole delay line; taps are compares
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_ff <= smcmp_pkg::ST_IDLE;
      cyc_ff   <= 7'h00;
      wr_ff    <= 1'b0;
    end else begin
      case (state_ff)
        smcmp_pkg::ST_IDLE: begin
          if (mem_start_pulse_in) begin
            state_ff <= smcmp_pkg::ST_READ;
            cyc_ff   <= 7'h00;
            wr_ff    <= 1'b0;
          end
        end
        smcmp_pkg::ST_READ: begin
          cyc_ff <= cyc_ff + 7'h01;
          if (cyc_ff == 7'(`SMCMP_T250_CYC) && write_request_in) begin
            state_ff <= smcmp_pkg::ST_WRITE;
            wr_ff    <= 1'b1;
          end else if (cyc_ff == 7'(`SMCMP_T500_CYC - 1)) begin
            state_ff <= smcmp_pkg::ST_IDLE;
          end
        end
        smcmp_pkg::ST_WRITE: begin
          cyc_ff <= cyc_ff + 7'h01;
          if (cyc_ff == 7'(`SMCMP_T750_CYC - 1)) begin
            state_ff <= smcmp_pkg::ST_IDLE;
            wr_ff    <= 1'b0;
          end
        end
        default: begin
          state_ff <= smcmp_pkg::ST_IDLE;
          cyc_ff   <= 7'h00;
          wr_ff    <= 1'b0;
        end
      endcase
    end
  end
  // start pulses seen while busy fall through the idle-only branch
  // ----------------------------------------------------------------
  // memory levels
  // ----------------------------------------------------------------
  // tap that carries chip select from the read end to the write end
  assign ce_hold_delay_tap = smcmp_win(cyc_ff, `SMCMP_CE_RD_CYC, `SMCMP_CE_WR_CYC);
  // levels decoded from flops; glitch-free as only one counter moves
  always_comb begin
    mem_lvl_out.precharge_level = busy &&
      smcmp_win(cyc_ff, `SMCMP_PCH_ON_CYC, `SMCMP_PCH_OFF_CYC);
    mem_lvl_out.chip_select_level = busy &&
      (smcmp_win(cyc_ff, `SMCMP_CE_ON_CYC, `SMCMP_CE_RD_CYC) ||
       (wr_ff && ce_hold_delay_tap));
    mem_lvl_out.read_write_level = wr_ff &&
      smcmp_win(cyc_ff, `SMCMP_WE_ON_CYC, `SMCMP_WE_OFF_CYC);
    mem_lvl_out.wdata_drive = wr_ff &&
      smcmp_win(cyc_ff, `SMCMP_WD_ON_CYC, `SMCMP_WD_OFF_CYC);
  end
  // ----------------------------------------------------------------
  // cycle attributes
  // ----------------------------------------------------------------
  // captured at start so the processor may move on during the cycle
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      fetch_ff <= 1'b0;
      half_ff  <= 1'b0;
      dsel_ff  <= 2'h0;
      rot_ff   <= 5'h00;
    end else if (!busy && mem_start_pulse_in) begin
      fetch_ff <= micro_fetch_in;
      half_ff  <= halfword_select_bit_in;
      dsel_ff  <= dest_sel_in;
      rot_ff   <= rot_amt_in;
    end
  end
  // ----------------------------------------------------------------
  // exchange and merge register
  // ----------------------------------------------------------------
  // write source onto the exchange
  always_comb begin
    case (src_sel_in)
      smcmp_pkg::SRC_X:    exch = {8'h00, x_reg_in};
      smcmp_pkg::SRC_Y:    exch = {8'h00, y_reg_in};
      smcmp_pkg::SRC_T:    exch = {8'h00, t_reg_in};
      smcmp_pkg::SRC_L:    exch = {8'h00, l_reg_in};
      smcmp_pkg::SRC_CONS: exch = {8'h00, console_sw_in};
      default:             exch = 32'h0000_0000;
    endcase
  end
  // merge register: write data at T250, merge at read sample, shared idle
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      merge_ff <= 32'h0000_0000;
      mask_ff  <= 32'h0000_0000;
    end else if (busy && cyc_ff == 7'(`SMCMP_T250_CYC) && write_request_in) begin
      merge_ff <= smcmp_rotl(exch, rot_ff);
      mask_ff  <= mask_in;
    end else if (smp && wr_ff) begin
      merge_ff <= (mask_ff & merge_ff) | (~mask_ff & mem_rdata_in);
    end else if (smp && !fetch_ff) begin
      merge_ff <= smcmp_rotl(mem_rdata_in, rot_ff);
    end else if (!busy && share_load_in) begin
      // the double pad swap uses plain storage, no rotation
      merge_ff <= share_rotate_in ? smcmp_rotl(share_data_in, rot_amt_in)
                                  : share_data_in;
    end
  end
  // ----------------------------------------------------------------
  // micro fetch path
  // ----------------------------------------------------------------
  // word read straight into the latch, no rotator in the way
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      fetch_latch_register_ff <= 32'h0000_0000;
      micro_pend_ff           <= 1'b0;
    end else begin
      micro_pend_ff <= smp && fetch_ff && !wr_ff;
      if (smp && fetch_ff && !wr_ff) begin
        fetch_latch_register_ff <= mem_rdata_in;
      end
    end
  end
  // halfword to the micro register one cycle after the latch loads
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      micro_ff <= 16'h0000;
    end else if (micro_pend_ff) begin
      micro_ff <= half_ff ? fetch_latch_register_ff[31:16]
                          : fetch_latch_register_ff[15:0];
    end
  end
  // destination load strobe after a move micro read
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      dest_load_ff <= 1'b0;
    end else begin
      dest_load_ff <= smp && !fetch_ff && !wr_ff;
    end
  end
  assign micro_reg_out  = micro_ff;
  assign micro_load_out = micro_pend_ff;
  assign merge_data_out = merge_ff;
  assign dest_sel_out   = dsel_ff;
  assign dest_load_out  = dest_load_ff;
  assign busy_out       = busy;
  // ----------------------------------------------------------------
  // parity check and generation
  // ----------------------------------------------------------------
  // per byte check: data plus parity must hold an odd count
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      chk_err[i] = (^{mem_rdata_in[8*i +: 8], mem_rpar_in[i]}) == 1'b0;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rd_err_ff <= 4'h0;
    end else if (smp) begin
      rd_err_ff <= chk_err;
    end
  end
  assign force_good_parity_code = (dfl_ff == `SMCMP_DFL_GOOD);
  assign not_force_bad_parity   = (dfl_ff != `SMCMP_DFL_BAD);
  // four sections; a bad byte stays bad unless length 25 overrides
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      parity_manipulate_term[i] = ~rd_err_ff[i] | force_good_parity_code;
      nxt_par[i] = (parity_manipulate_term[i] && not_force_bad_parity)
                   ? smcmp_odd(merge_ff[8*i +: 8])
                   : ~smcmp_odd(merge_ff[8*i +: 8]);
    end
  end
  // parity is taken from the merged word, only in write cycles
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      wpar_ff <= 4'h0;
    end else if (wr_ff && cyc_ff == 7'(`SMCMP_WD_ON_CYC - 1)) begin
      wpar_ff <= nxt_par;
    end
  end
  assign merged_write_levels_out = merge_ff;
  assign module_parity_out       = wpar_ff;
  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  assign acc    = apb_in.psel && apb_in.penable;
  assign map_ok = (apb_in.paddr[7:2] == `SMCMP_CTRL_OFS) || (apb_in.paddr[7:2] == `SMCMP_STAT_OFS);
  assign st_clr = acc && apb_in.pwrite && apb_in.paddr[7:2] == `SMCMP_STAT_OFS &&
                  apb_in.pwdata[`SMCMP_ST_PERR_BIT];
  // field length code steering the parity sections
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      dfl_ff <= `SMCMP_CTRL_RST;
    end else if (acc && apb_in.pwrite && apb_in.paddr[7:2] == `SMCMP_CTRL_OFS) begin
      dfl_ff <= apb_in.pwdata[4:0];
    end
  end
  // sticky parity error flag; a new error beats a clear
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      perr_ff <= 1'b0;
    end else if (smp && (|chk_err)) begin
      perr_ff <= 1'b1;
    end else if (st_clr) begin
      perr_ff <= 1'b0;
    end
  end
  // kind of the running cycle so far, held after it ends
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      last_wr_ff <= 1'b0;
    end else if (state_ff == smcmp_pkg::ST_WRITE) begin
      last_wr_ff <= 1'b1;
    end else if (state_ff == smcmp_pkg::ST_READ) begin
      last_wr_ff <= 1'b0;
    end
  end
  // read data captured in setup so the access needs no wait
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      prdata_ff <= 32'h0000_0000;
    end else if (apb_in.psel && !apb_in.penable) begin
      case (apb_in.paddr[7:2])
        `SMCMP_CTRL_OFS: prdata_ff <= {27'h0000000, dfl_ff};
        `SMCMP_STAT_OFS: prdata_ff <= {29'h00000000, last_wr_ff, busy, perr_ff};
        default:         prdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign pready_out  = 1'b1;
  assign pslverr_out = acc && !map_ok;
  assign prdata_out  = prdata_ff;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_START_TAKEN: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !busy && mem_start_pulse_in |=> state_ff == smcmp_pkg::ST_READ && cyc_ff == 7'h00)
    else $error("start pulse not taken");
  AST_READ_END: assert property (@(posedge core_clk_in) disable iff (srst_in)
    state_ff == smcmp_pkg::ST_READ && cyc_ff == 7'(`SMCMP_T500_CYC - 1)
    |=> !busy) else $error("read did not end at T500");
  AST_WRITE_STRETCH: assert property (@(posedge core_clk_in) disable iff (srst_in)
    state_ff == smcmp_pkg::ST_READ && cyc_ff == 7'(`SMCMP_T250_CYC) && write_request_in
    |=> wr_ff && busy) else $error("write request did not stretch cycle");
  AST_CE_PAST_T500: assert property (@(posedge core_clk_in) disable iff (srst_in)
    wr_ff && cyc_ff == 7'(`SMCMP_T500_CYC)
    |-> mem_lvl_out.chip_select_level) else $error("chip select dropped at T500 in write");
  AST_CE_OFF_WR: assert property (@(posedge core_clk_in) disable iff (srst_in)
    wr_ff && cyc_ff == 7'(`SMCMP_CE_WR_CYC)
    |-> !mem_lvl_out.chip_select_level) else $error("chip select late in write");
  AST_RW_LOW_RD: assert property (@(posedge core_clk_in) disable iff (srst_in)
    state_ff == smcmp_pkg::ST_READ |-> !mem_lvl_out.read_write_level)
    else $error("write level in read");
  AST_PCH_RISE: assert property (@(posedge core_clk_in) disable iff (srst_in)
    busy && cyc_ff == 7'(`SMCMP_PCH_ON_CYC - 1)
    |-> !mem_lvl_out.precharge_level ##1 mem_lvl_out.precharge_level)
    else $error("precharge edge misplaced");
  AST_WE_WINDOW: assert property (@(posedge core_clk_in) disable iff (srst_in)
    wr_ff && cyc_ff == 7'(`SMCMP_WE_ON_CYC)
    |-> mem_lvl_out.read_write_level [*4]) else $error("write level window short");
  AST_HALFWORD: assert property (@(posedge core_clk_in) disable iff (srst_in)
    micro_pend_ff |=> micro_ff == (half_ff ? fetch_latch_register_ff[31:16]
                                           : fetch_latch_register_ff[15:0]))
    else $error("wrong halfword to micro register");
  AST_PERR_SET: assert property (@(posedge core_clk_in) disable iff (srst_in)
    smp && (|chk_err) |=> perr_ff) else $error("parity error not flagged");
  AST_BAD_PARITY: assert property (@(posedge core_clk_in) disable iff (srst_in)
    mem_lvl_out.wdata_drive && !not_force_bad_parity && $stable(merge_ff)
    |-> (^{merge_ff[7:0], wpar_ff[0]}) == 1'b0) else $error("length 26 parity not bad");
  AST_IGNORE_START: assert property (@(posedge core_clk_in) disable iff (srst_in)
    busy && mem_start_pulse_in && cyc_ff != 7'h7f |=> cyc_ff != 7'h00)
    else $error("start pulse restarted a running cycle");
endmodule : smcmp_seq

// ===== design/smcmp_defines.svh
// offsets, fields, reset values and timing counts for the memory sequencer
// assumes a 125 MHz core clock; every timing point counts from the start edge
`ifndef SMCMP_DEFINES_SVH
`define SMCMP_DEFINES_SVH
`define SMCMP_CLK_NS       8
`define SMCMP_UP(ns)       (((ns) + `SMCMP_CLK_NS - 1) / `SMCMP_CLK_NS)
`define SMCMP_DN(ns)       ((ns) / `SMCMP_CLK_NS)
// timing points in ns
`define SMCMP_T250_NS      250
`define SMCMP_T500_NS      500
`define SMCMP_T750_NS      750
`define SMCMP_PCH_ON_NS    87
`define SMCMP_PCH_OFF_NS   235
`define SMCMP_CE_ON_NS     193
`define SMCMP_CE_RD_OFF_NS 475
`define SMCMP_CE_WR_OFF_NS 710
`define SMCMP_WE_ON_NS     520
`define SMCMP_WE_OFF_NS    710
`define SMCMP_WD_ON_NS     530
`define SMCMP_WD_OFF_NS    750
`define SMCMP_RD_SMP_NS    450
// timing points in cycles
`define SMCMP_T250_CYC     `SMCMP_UP(`SMCMP_T250_NS)
`define SMCMP_T500_CYC     `SMCMP_UP(`SMCMP_T500_NS)
`define SMCMP_T750_CYC     `SMCMP_UP(`SMCMP_T750_NS)
`define SMCMP_PCH_ON_CYC   `SMCMP_UP(`SMCMP_PCH_ON_NS)
`define SMCMP_PCH_OFF_CYC  `SMCMP_DN(`SMCMP_PCH_OFF_NS)
`define SMCMP_CE_ON_CYC    `SMCMP_UP(`SMCMP_CE_ON_NS)
`define SMCMP_CE_RD_CYC    `SMCMP_DN(`SMCMP_CE_RD_OFF_NS)
`define SMCMP_CE_WR_CYC    `SMCMP_DN(`SMCMP_CE_WR_OFF_NS)
`define SMCMP_WE_ON_CYC    `SMCMP_UP(`SMCMP_WE_ON_NS)
`define SMCMP_WE_OFF_CYC   `SMCMP_DN(`SMCMP_WE_OFF_NS)
`define SMCMP_WD_ON_CYC    `SMCMP_UP(`SMCMP_WD_ON_NS)
`define SMCMP_WD_OFF_CYC   `SMCMP_DN(`SMCMP_WD_OFF_NS)
`define SMCMP_RD_SMP_CYC   `SMCMP_UP(`SMCMP_RD_SMP_NS)
// field length codes
`define SMCMP_DFL_GOOD     5'h19
`define SMCMP_DFL_BAD      5'h1a
// register map
`define SMCMP_CTRL_OFS     6'h00
`define SMCMP_STAT_OFS     6'h01
`define SMCMP_CTRL_RST     5'h00
`define SMCMP_ST_PERR_BIT  0
`define SMCMP_ST_BUSY_BIT  1
`define SMCMP_ST_WR_BIT    2
`endif

// ===== design/smcmp_pkg.sv
// types shared by the memory sequencer and its surroundings
// assumes an apb master on the core clock
package smcmp_pkg;
  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } smcmp_apb_req_t;
  // levels towards the memory modules
  typedef struct packed {
    logic precharge_level;
    logic chip_select_level;
    logic read_write_level;
    logic wdata_drive;
  } smcmp_mem_lvl_t;
  // write data source on the exchange
  typedef enum logic [2:0] {
    SRC_X = 3'h0, SRC_Y = 3'h1, SRC_T = 3'h2, SRC_L = 3'h3, SRC_CONS = 3'h4
  } smcmp_src_t;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_READ = 3'h2, ST_WRITE = 3'h4
  } smcmp_state_t;
endpackage : smcmp_pkg

// ===== dv/smcmp_mem_model.sv
// behavioural model of the four byte-wide memory modules behind the sequencer
// assumes one storage word; levels and write data come from the sequencer
module smcmp_mem_model (
  // clock
  input  wire logic                      clk_in,
  // levels and write data from the sequencer
  input  wire smcmp_pkg::smcmp_mem_lvl_t lvl_in,
  input  wire logic [31:0]               wdata_in,
  input  wire logic [3:0]                wpar_in,
  // fault injection: flip byte 0 parity on reads
  input  wire logic                      flip_par_in,
  // read side towards the sequencer
  output logic [31:0]                    rdata_out,
  output logic [3:0]                     rpar_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] word_ff = 32'h0000_0000;
  logic [3:0]  par_ff  = 4'hf;
  // store only while write level and write data both stand
  always_ff @(posedge clk_in) begin
    if (lvl_in.read_write_level && lvl_in.wdata_drive) begin
      word_ff <= wdata_in;
      par_ff  <= wpar_in;
    end
  end
  // unselected outputs float: show the inverse so a late sample is caught
  assign rdata_out = lvl_in.chip_select_level ? word_ff : ~word_ff;
  assign rpar_out  = (lvl_in.chip_select_level ? par_ff : ~par_ff) ^ {3'h0, flip_par_in};
endmodule : smcmp_mem_model

// ===== dv/tb.sv
// self-checking bench for the memory sequencer, merge register and parity
// assumes the memory model in smcmp_mem_model and a 125 MHz core clock
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, start = 1'b0, wreq = 1'b0, fetch = 1'b0, hsel = 1'b0;
  logic flip = 1'b0, shl = 1'b0, shr = 1'b0, pready, pslverr, busy, mload, dlo, e;
  logic [1:0] dsel = 2'h0, dso;
  logic [4:0] rot = 5'h0;
  logic [15:0] mreg;
  logic [31:0] mask = 32'h0, shd = 32'h0, prdata, mdata, rdata, wlev, q, m, ew;
  logic [3:0] rpar, mpar, ep, er, np;
  logic [23:0] sv [5] = '{default: 24'h0};
  smcmp_pkg::smcmp_src_t srcs = smcmp_pkg::SRC_X;
  smcmp_pkg::smcmp_apb_req_t apb_req = '0;
  smcmp_pkg::smcmp_mem_lvl_t lvl;
  int fails = 0, compares = 0, cyc = 0, cnt [7];
  logic [4:0] data_field_length [6] = '{5'h19, 5'h00, 5'h1a, 5'h00, 5'h19, 5'h00};
  logic flg = 1'b0;
  smcmp_seq i_dut (.core_clk_in(clk), .srst_in(srst), .apb_in(apb_req), .pready_out(pready),
    .pslverr_out(pslverr), .prdata_out(prdata), .mem_start_pulse_in(start),
    .write_request_in(wreq), .micro_fetch_in(fetch), .halfword_select_bit_in(hsel),
    .dest_sel_in(dsel), .rot_amt_in(rot), .mask_in(mask), .src_sel_in(srcs),
    .x_reg_in(sv[0]), .y_reg_in(sv[1]), .t_reg_in(sv[2]), .l_reg_in(sv[3]),
    .console_sw_in(sv[4]), .share_load_in(shl), .share_rotate_in(shr),
    .share_data_in(shd), .busy_out(busy), .micro_reg_out(mreg), .micro_load_out(mload),
    .merge_data_out(mdata), .dest_sel_out(dso), .dest_load_out(dlo), .mem_lvl_out(lvl),
    .mem_rdata_in(rdata), .mem_rpar_in(rpar), .merged_write_levels_out(wlev),
    .module_parity_out(mpar));
  smcmp_mem_model i_mem (.clk_in(clk), .lvl_in(lvl), .wdata_in(wlev), .wpar_in(mpar),
    .flip_par_in(flip), .rdata_out(rdata), .rpar_out(rpar));
  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
  // odd parity per byte and left rotation
  function automatic logic [3:0] opar(input logic [31:0] d);
    for (int i = 0; i < 4; i++) opar[i] = ~^d[8*i +: 8];
  endfunction : opar
  function automatic logic [31:0] rotl(input logic [31:0] v, input logic [4:0] n);
    return (v << n) | (v >> (6'd32 - n));
  endfunction : rotl
  task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask : cmp
  // apb master: setup, then access held until pready is sampled high
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb_req <= '0;
  endtask : apb_xfer
  // one memory cycle; counts busy and level cycles, pulses a stray start mid-cycle
  task automatic run(input logic wr);
    cnt = '{default: 0};
    @(posedge clk);
    start <= 1'b1;
    wreq  <= wr;
    @(posedge clk);
    start <= 1'b0;
    repeat (200) begin
      #1;
      if (busy !== 1'b1) break;
      cnt[0] += 1;
      cnt[1] += (lvl.precharge_level === 1'b1);
      cnt[2] += (lvl.chip_select_level === 1'b1);
      cnt[3] += (lvl.read_write_level === 1'b1);
      cnt[4] += (lvl.wdata_drive === 1'b1);
      cnt[5] += (mload === 1'b1);
      cnt[6] += (dlo === 1'b1);
      @(posedge clk);
      start <= (cnt[0] == 9);
    end
    cmp("busy", wr ? 94 : 63, cnt[0]);
    cmp("precharge", 18, cnt[1]);
    cmp("chip_sel", wr ? 63 : 34, cnt[2]);
    cmp("rw_level", wr ? 23 : 0, cnt[3]);
    cmp("wdata_drv", wr ? 26 : 0, cnt[4]);
    cmp("micro_load", (!wr && fetch) ? 1 : 0, cnt[5]);
    cmp("dest_load", (!wr && !fetch) ? 1 : 0, cnt[6]);
  endtask : run
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    void'($urandom(32'h435e));
    ew = 32'h0;
    ep = 4'hf;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    apb_xfer(1'b0, 8'h04, 32'h0);
    cmp("status_rst", 0, q);
    apb_xfer(1'b1, 8'h08, 32'h0);
    cmp("unmapped_err", 1, e);
    for (int i = 0; i < 6; i++) begin
      apb_xfer(1'b1, 8'h00, {27'h0, data_field_length[i]});
      @(posedge clk);
      foreach (sv[k]) sv[k] <= 24'($urandom);
      srcs <= smcmp_pkg::smcmp_src_t'($urandom_range(4));
      mask <= $urandom;
      rot  <= 5'($urandom);
      flip <= (i == 1 || i == 4);
      @(posedge clk);
      er = (ep ^ {3'h0, flip}) ^ opar(ew);
      m  = (rotl({8'h0, sv[srcs]}, rot) & mask) | (ew & ~mask);
      np = (data_field_length[i] == 5'h1a) ? ~opar(m) : (data_field_length[i] == 5'h19) ? opar(m) : opar(m) ^ er;
      flg |= |er;
      run(1'b1);
      cmp("merged", m, wlev);
      cmp("parity", np, mpar);
      ew = m;
      ep = np;
    end
    apb_xfer(1'b0, 8'h00, 32'h0);
    cmp("dfl_rd", {27'h0, data_field_length[5]}, q);
    flip <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      @(posedge clk);
      fetch <= (j < 2);
      hsel  <= j[0];
      rot   <= 5'($urandom_range(31, 1));
      dsel  <= 2'($urandom);
      run(1'b0);
      if (j < 2) cmp("micro", j[0] ? ew[31:16] : ew[15:0], mreg);
      else cmp("move", rotl(ew, rot), mdata);
      if (j >= 2) cmp("dest", dsel, dso);
    end
    apb_xfer(1'b0, 8'h04, 32'h0);
    cmp("perr_flag", flg, q[0]);
    apb_xfer(1'b1, 8'h04, 32'h1);
    apb_xfer(1'b0, 8'h04, 32'h0);
    cmp("perr_clr", 0, q[0]);
    // shared merge use: plain storage first, then through the rotator
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      shd <= $urandom;
      shr <= s[0];
      shl <= 1'b1;
      @(posedge clk);
      shl <= 1'b0;
      @(posedge clk);
      #1;
      cmp("share", s[0] ? rotl(shd, rot) : shd, mdata);
    end
    wrap_up();
  end
endmodule : tb
